// ==== logic/t1rx_defs.svh ====
// Register offsets, field positions, reset values and stream constants
`ifndef T1RX_DEFS_SVH
`define T1RX_DEFS_SVH
`define T1RX_NFRAMER 8
`define T1RX_FRAMER_STRIDE 10'h080
`define T1RX_OFF_LINE 7'h00
`define T1RX_OFF_SIF 7'h01
`define T1RX_OFF_PAR 7'h02
`define T1RX_LINE_RST 8'h00
`define T1RX_SIF_RST 8'hC0
`define T1RX_PAR_RST 8'h00
`define T1RX_PAR_RW_MASK 8'hCB
// Receive line options fields
`define T1RX_B_FIFO_SKIP 7
`define T1RX_B_UNFRAMED 6
`define T1RX_B_LOOP_EXCL 5
`define T1RX_B_AUTO_YEL 3
`define T1RX_B_AUTO_RED 2
`define T1RX_B_AUTO_OOF 1
`define T1RX_B_AUTO_XFER 0
// Receive system interface fields
`define T1RX_F_MODE 7:6
`define T1RX_B_REF_SEL 5
`define T1RX_B_RATE_A 4
`define T1RX_B_RATE_B 3
`define T1RX_B_FP_MF 2
`define T1RX_B_FP_ALT 1
`define T1RX_B_TC_SCOPE 0
// Parity fields
`define T1RX_B_TX_TYPE 7
`define T1RX_B_TX_IRQ 6
`define T1RX_B_TX_DFLAG 5
`define T1RX_B_TX_SFLAG 4
`define T1RX_B_FBIT_INC 3
`define T1RX_B_RX_TYPE 1
`define T1RX_B_RX_EN 0
// Jitter FIFO latency in bits, frame length in bits, 8 kHz high half
`define T1RX_FIFO_DEPTH 24
`define T1RX_BITS_PER_FRAME 8'd193
`define T1RX_REF_HIGH_BITS 8'd97
`endif

// ==== logic/t1rx_pkg.sv ====
// Types shared by the receive line and backplane control block
package t1rx_pkg;
   typedef enum logic [1:0] {T1RX_MASTER_FRAC, T1RX_MASTER_FULL, T1RX_SLAVE_REF,
      T1RX_SLAVE_SIG} t1rx_mode_e;
   typedef enum logic [1:0] {T1RX_RATE_1M5, T1RX_RATE_8M2, T1RX_RATE_2M0,
      T1RX_RATE_RSVD} t1rx_rate_e;
   typedef logic [7:0] t1rx_reg_t;
endpackage

// ==== logic/t1rx_ctrl.sv ====
// Eight-framer receive line, backplane and parity control
//
// How it works
// RULE_01: eight register copies, 0x80 byte stride
// RULE_02: skip bit bypasses 24-bit jitter delay
// RULE_03: unframed stops search, freezes signaling, flags loss
// RULE_04: loop-code compare skips F-bit results
// RULE_05: remote alarm auto on red, else manual
// RULE_06: auto conditioning replaces data on red
// RULE_07: auto conditioning during frame alignment loss
// RULE_08: counters transfer per second or on request
// RULE_09: two-bit receive path mode, resets 11
// RULE_10: full mode clocks out all 193 bits
// RULE_11: fractional mode clocks selected channels only
// RULE_12: shared pin gives 8 kHz or line clock
// RULE_13: shared pin carries channel-aligned signaling
// RULE_14: two bits select backplane bit rate
// RULE_15: software keeps rate and mode consistent
// RULE_16: frame pulse every, alternate or multiframe
// RULE_17: mux frame pulse from first mux framer
// RULE_18: scope bit: per-slot or all-slot conditioning
// RULE_19: software enables payload control before all-slot use
// RULE_20: transmit F-bit parity expectation by type
// RULE_21: data and signaling parity flags clear on read
// RULE_22: parity errors drive interrupt when enabled
// RULE_23: extended bit includes F-bit in parity
// RULE_24: receive parity inserted into output F-bit
// RULE_25: settings take effect at frame boundary
`timescale 1ns/10ps
`include "t1rx_defs.svh"

module t1rx_ctrl
   import t1rx_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [9:0] i_addr,
   input wire logic i_wr_stb,
   input wire logic i_rd_stb,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   input wire logic [7:0] i_line_bit_stb,
   input wire logic [7:0] i_line_bit,
   input wire logic [7:0] i_line_fbit,
   input wire logic [7:0] i_line_mf_start,
   input wire logic [7:0] i_ext_sig_bit,
   input wire logic [7:0] i_channel_select_bit,
   input wire logic [7:0] i_ts_condition,
   input wire logic [7:0] i_trunk_data_bit,
   input wire logic [7:0] i_trunk_sig_bit,
   input wire logic [7:0] i_red_alarm,
   input wire logic [7:0] i_frame_loss_indication,
   input wire logic [7:0] i_manual_remote_alarm,
   input wire logic i_one_second_tick,
   input wire logic [7:0] i_mcu_transfer_req,
   input wire logic [7:0] i_tx_bit_stb,
   input wire logic [7:0] i_tx_fbit,
   input wire logic [7:0] i_tx_mf_start,
   input wire logic [7:0] i_tx_backplane_data,
   input wire logic [7:0] i_tx_backplane_signaling,
   output logic [7:0] o_rx_backplane_data,
   output logic [7:0] o_rx_backplane_signaling,
   output logic [7:0] o_rx_backplane_clock_out,
   output logic [7:0] o_rx_frame_pulse,
   output logic o_mux_rx_frame_pulse,
   output logic [15:0] o_backplane_rate,
   output logic [7:0] o_frame_search_en,
   output logic [7:0] o_sig_buffer_freeze,
   output logic [7:0] o_loop_cmp_stb,
   output logic [7:0] o_send_remote_alarm,
   output logic [7:0] o_counter_transfer,
   output logic o_irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register port decode
   logic [2:0] sel_framer;
   logic [6:0] sel_off;
   logic [7:0] rd_line [0:7];
   logic [7:0] rd_sif [0:7];
   logic [7:0] rd_par [0:7];
   logic [7:0] rd_mux;
   logic [7:0] irq_vec;
   logic [7:0] mux_fp_vec;
   logic [7:0] mux_member;

   // Framer copy and offset within the 0x80 window
   assign sel_framer = i_addr[9:7]; // RULE_01
   assign sel_off = i_addr[6:0];

   // Selecting one copy; unmapped offsets read zero
   function automatic logic hit(input logic [2:0] f, input logic [6:0] off,
      input logic [2:0] fr, input logic [6:0] o);
      hit = (f == fr) && (off == o);
   endfunction

   assign rd_mux = (sel_off == `T1RX_OFF_LINE) ? rd_line[sel_framer] :
      (sel_off == `T1RX_OFF_SIF) ? rd_sif[sel_framer] :
      (sel_off == `T1RX_OFF_PAR) ? rd_par[sel_framer] : 8'h00;

   // Read data held until the next read
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= 8'h00;
      end else if (i_rd_stb) begin
         o_rdata <= rd_mux;
      end
   end

   assign o_irq = |irq_vec; // RULE_22

   // First framer on the multiplexed rate owns the mux frame pulse
   assign o_mux_rx_frame_pulse = |(mux_fp_vec & mux_member & ~(mux_member - 8'h01)); // RULE_17

   ////////////////////////////////////////////////////////////////////////////////
   // Per-framer logic
   genvar g;
   generate
      for (g = 0; g < `T1RX_NFRAMER; g++) begin : gen_fr
         logic [7:0] line_q, sif_q, par_q;
         logic [7:0] act_line_q, act_sif_q, act_par_q;
         logic dflag_q, sflag_q;
         logic [3:0] dly_q [0:`T1RX_FIFO_DEPTH-1];
         logic [3:0] now_v, path_v;
         logic p_data, p_sig, p_f, p_mf, stb;
         t1rx_mode_e mode;
         logic frac, out_of_alignment, cond, replace, par_on, ins_f;
         logic [7:0] cnt_q;
         logic fcnt_q, refclk_q, rpar_d_q, rpar_s_q;
         logic out_d, out_s, fp;
         logic [3:0] txa_q, txb_q;
         logic [1:0] txd_a_q, txd_b_q;
         logic tpar_d_q, tpar_s_q, tx_seen_q;
         logic t_stb, t_f, t_mf, t_d, t_s, t_inc, t_check, derr, serr;
         logic wr_line, wr_sif, wr_par, rd_clr;

         assign wr_line = i_wr_stb && hit(sel_framer, sel_off, 3'(g), `T1RX_OFF_LINE);
         assign wr_sif = i_wr_stb && hit(sel_framer, sel_off, 3'(g), `T1RX_OFF_SIF);
         assign wr_par = i_wr_stb && hit(sel_framer, sel_off, 3'(g), `T1RX_OFF_PAR);
         assign rd_clr = i_rd_stb && hit(sel_framer, sel_off, 3'(g), `T1RX_OFF_PAR); // RULE_21
         assign rd_line[g] = line_q;
         assign rd_sif[g] = sif_q;
         assign rd_par[g] = {par_q[7:6], dflag_q, sflag_q, par_q[3:0]};

         // Software copies of this framer's registers
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               line_q <= `T1RX_LINE_RST;
               sif_q <= `T1RX_SIF_RST; // RULE_09
               par_q <= `T1RX_PAR_RST;
            end else begin
               if (wr_line) line_q <= i_wdata;
               if (wr_sif) sif_q <= i_wdata;
               if (wr_par) par_q <= i_wdata & `T1RX_PAR_RW_MASK;
            end
         end

         // Jitter delay line; bypass trims the fixed latency
         assign stb = i_line_bit_stb[g];
         assign now_v = {i_line_bit[g], i_ext_sig_bit[g], i_line_fbit[g], i_line_mf_start[g]};
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               for (int k = 0; k < `T1RX_FIFO_DEPTH; k++) dly_q[k] <= 4'h0;
            end else if (stb) begin
               dly_q[0] <= now_v;
               for (int k = 1; k < `T1RX_FIFO_DEPTH; k++) dly_q[k] <= dly_q[k-1];
            end
         end
         assign path_v = act_line_q[`T1RX_B_FIFO_SKIP] ? now_v
            : dly_q[`T1RX_FIFO_DEPTH-1]; // RULE_02
         assign {p_data, p_sig, p_f, p_mf} = path_v;

         // Active copies reload only on an F-bit so a frame never mixes settings
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               act_line_q <= `T1RX_LINE_RST;
               act_sif_q <= `T1RX_SIF_RST;
               act_par_q <= `T1RX_PAR_RST;
            end else if (stb && p_f) begin
               act_line_q <= line_q; // RULE_25
               act_sif_q <= sif_q;
               act_par_q <= par_q;
            end
         end

         // Mode decode and conditioning causes
         assign mode = t1rx_mode_e'(act_sif_q[`T1RX_F_MODE]); // RULE_09
         assign frac = (mode == T1RX_MASTER_FRAC);
         assign out_of_alignment = i_frame_loss_indication[g] | act_line_q[`T1RX_B_UNFRAMED]; // RULE_03
         assign cond = (act_line_q[`T1RX_B_AUTO_RED] & i_red_alarm[g]) // RULE_06
            | (act_line_q[`T1RX_B_AUTO_OOF] & out_of_alignment); // RULE_07
         assign replace = cond | act_sif_q[`T1RX_B_TC_SCOPE] | i_ts_condition[g]; // RULE_18
         assign par_on = act_par_q[`T1RX_B_RX_EN] & ~frac;
         assign ins_f = par_on & p_f & p_mf; // RULE_24
         assign out_d = ins_f ? (rpar_d_q ^ act_par_q[`T1RX_B_RX_TYPE])
            : (replace & ~p_f) ? i_trunk_data_bit[g] : p_data;
         assign out_s = ins_f ? (rpar_s_q ^ act_par_q[`T1RX_B_RX_TYPE])
            : (replace & ~p_f) ? i_trunk_sig_bit[g] : p_sig; // RULE_13
         assign fp = p_f & (act_sif_q[`T1RX_B_FP_MF] ? p_mf
            : act_sif_q[`T1RX_B_FP_ALT] ? fcnt_q : 1'b1); // RULE_16
         assign mux_fp_vec[g] = stb & p_f;
         assign mux_member[g] = (act_sif_q[`T1RX_B_RATE_A:`T1RX_B_RATE_B] == 2'b01);
         assign o_backplane_rate[2*g+1:2*g] = act_sif_q[`T1RX_B_RATE_A:`T1RX_B_RATE_B]; // RULE_14

         // Backplane output stage, updated per line bit
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               o_rx_backplane_data[g] <= 1'b0;
               o_rx_backplane_signaling[g] <= 1'b0;
               o_rx_backplane_clock_out[g] <= 1'b0;
               o_rx_frame_pulse[g] <= 1'b0;
               cnt_q <= 8'h00;
               fcnt_q <= 1'b0;
               refclk_q <= 1'b0;
            end else begin
               o_rx_backplane_clock_out[g] <= stb & ((mode == T1RX_MASTER_FULL) // RULE_10
                  | (frac & i_channel_select_bit[g])); // RULE_11
               if (stb) begin
                  o_rx_backplane_data[g] <= out_d;
                  o_rx_frame_pulse[g] <= fp;
                  cnt_q <= p_f ? 8'h00 : cnt_q + 8'h01;
                  if (p_f) fcnt_q <= ~fcnt_q;
                  refclk_q <= ~refclk_q;
               end
               // Shared pin: reference clock or extracted signaling
               if (mode == T1RX_SLAVE_REF) begin
                  o_rx_backplane_signaling[g] <= act_sif_q[`T1RX_B_REF_SEL] ? refclk_q
                     : (cnt_q < `T1RX_REF_HIGH_BITS); // RULE_12
               end else if (stb) begin
                  o_rx_backplane_signaling[g] <= out_s;
               end
            end
         end

         // Receive parity over the superframe just sent
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               rpar_d_q <= 1'b0;
               rpar_s_q <= 1'b0;
            end else if (stb) begin
               if (p_f && p_mf) begin
                  rpar_d_q <= act_par_q[`T1RX_B_FBIT_INC] & out_d; // RULE_23
                  rpar_s_q <= act_par_q[`T1RX_B_FBIT_INC] & out_s;
               end else if (!p_f || act_par_q[`T1RX_B_FBIT_INC]) begin
                  rpar_d_q <= rpar_d_q ^ out_d;
                  rpar_s_q <= rpar_s_q ^ out_s;
               end
            end
         end

         // Transmit pins synchronised; markers delayed equally to stay aligned
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               txd_a_q <= 2'b00;
               txd_b_q <= 2'b00;
               txa_q <= 4'h0;
               txb_q <= 4'h0;
            end else begin
               txd_a_q <= {i_tx_backplane_data[g], i_tx_backplane_signaling[g]};
               txd_b_q <= txd_a_q;
               txa_q <= {i_tx_bit_stb[g], i_tx_fbit[g], i_tx_mf_start[g], 1'b0};
               txb_q <= txa_q;
            end
         end
         assign {t_stb, t_f, t_mf} = txb_q[3:1];
         assign {t_d, t_s} = txd_b_q;
         assign t_inc = act_par_q[`T1RX_B_FBIT_INC];
         assign t_check = t_stb & t_f & t_mf & tx_seen_q;
         // Expected F is one when the count parity disagrees with the type
         assign derr = t_check & (t_d != (tpar_d_q ^ act_par_q[`T1RX_B_TX_TYPE])); // RULE_20
         assign serr = t_check & (t_s != (tpar_s_q ^ act_par_q[`T1RX_B_TX_TYPE]));

         // Transmit parity accumulation and sticky flags; a new error beats the read
         always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               tpar_d_q <= 1'b0;
               tpar_s_q <= 1'b0;
               tx_seen_q <= 1'b0;
               dflag_q <= 1'b0;
               sflag_q <= 1'b0;
            end else begin
               if (t_stb && t_f && t_mf) begin
                  tpar_d_q <= t_inc & t_d; // RULE_23
                  tpar_s_q <= t_inc & t_s;
                  tx_seen_q <= 1'b1;
               end else if (t_stb && (!t_f || t_inc)) begin
                  tpar_d_q <= tpar_d_q ^ t_d;
                  tpar_s_q <= tpar_s_q ^ t_s;
               end
               dflag_q <= derr | (dflag_q & ~rd_clr); // RULE_21
               sflag_q <= serr | (sflag_q & ~rd_clr);
            end
         end
         assign irq_vec[g] = act_par_q[`T1RX_B_TX_IRQ] & ~frac & (dflag_q | sflag_q); // RULE_22

         // Line-option controls toward neighbouring blocks
         assign o_frame_search_en[g] = ~act_line_q[`T1RX_B_UNFRAMED]; // RULE_03
         assign o_sig_buffer_freeze[g] = act_line_q[`T1RX_B_UNFRAMED];
         assign o_loop_cmp_stb[g] = stb & ~p_f; // RULE_04
         assign o_send_remote_alarm[g] = (act_line_q[`T1RX_B_AUTO_YEL] & i_red_alarm[g])
            | i_manual_remote_alarm[g]; // RULE_05
         assign o_counter_transfer[g] = act_line_q[`T1RX_B_AUTO_XFER] ? i_one_second_tick
            : i_mcu_transfer_req[g]; // RULE_08
      end
   endgenerate

endmodule

// ==== tb/t1rx_ctrl_asserts.sv ====
// Port-level checker for the receive control block
`timescale 1ns/10ps
module t1rx_ctrl_asserts (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_rd_stb,
   input wire logic [7:0] i_line_bit_stb,
   input wire logic i_one_second_tick,
   input wire logic [7:0] i_mcu_transfer_req,
   input wire logic [7:0] i_red_alarm,
   input wire logic [7:0] i_manual_remote_alarm,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_rx_backplane_data,
   input wire logic [7:0] o_rx_backplane_clock_out,
   input wire logic o_mux_rx_frame_pulse,
   input wire logic [7:0] o_frame_search_en,
   input wire logic [7:0] o_sig_buffer_freeze,
   input wire logic [7:0] o_loop_cmp_stb,
   input wire logic [7:0] o_send_remote_alarm,
   input wire logic [7:0] o_counter_transfer
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////
   // Output events must trace back to their cause at the inputs; search and freeze must stay complementary
   loop_cmp_stb_a: assert property ((o_loop_cmp_stb & ~i_line_bit_stb) == 8'h00)
      else $error("loop compare strobe without line strobe");
   clk_after_stb_a: assert property (o_rx_backplane_clock_out[0] |-> $past(i_line_bit_stb[0]))
      else $error("clock pulse without line strobe");
   data_hold_a: assert property (!$past(i_line_bit_stb[0]) |-> $stable(o_rx_backplane_data[0]))
      else $error("data moved between strobes");
   rdata_hold_a: assert property (!$past(i_rd_stb) |-> $stable(o_rdata))
      else $error("read data moved without read");
   xfer_cause_a: assert property ((o_counter_transfer
      & ~({8{i_one_second_tick}} | i_mcu_transfer_req)) == 8'h00)
      else $error("counter transfer without cause");
   alarm_cause_a: assert property ((o_send_remote_alarm & ~(i_red_alarm | i_manual_remote_alarm)) == 8'h00)
      else $error("remote alarm without cause");
   mux_fp_cause_a: assert property (o_mux_rx_frame_pulse |-> (|i_line_bit_stb))
      else $error("mux frame pulse without strobe");
   search_freeze_a: assert property (o_frame_search_en == ~o_sig_buffer_freeze)
      else $error("search and freeze disagree");
   // Main scenarios reached
   cover property (o_rx_backplane_clock_out[0]);
   cover property (o_counter_transfer[0]);
   cover property (o_mux_rx_frame_pulse);
endmodule
bind t1rx_ctrl t1rx_ctrl_asserts i_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
   .i_rd_stb(i_rd_stb), .i_line_bit_stb(i_line_bit_stb), .i_one_second_tick(i_one_second_tick),
   .i_mcu_transfer_req(i_mcu_transfer_req), .i_red_alarm(i_red_alarm),
   .i_manual_remote_alarm(i_manual_remote_alarm), .o_rdata(o_rdata),
   .o_rx_backplane_data(o_rx_backplane_data), .o_rx_backplane_clock_out(o_rx_backplane_clock_out),
   .o_mux_rx_frame_pulse(o_mux_rx_frame_pulse), .o_frame_search_en(o_frame_search_en),
   .o_sig_buffer_freeze(o_sig_buffer_freeze), .o_loop_cmp_stb(o_loop_cmp_stb),
   .o_send_remote_alarm(o_send_remote_alarm), .o_counter_transfer(o_counter_transfer));

// ==== tb/t1rx_far_end.sv ====
// Far-end backplane model: tallies receive output, sources transmit pins
`timescale 1ns/10ps
module t1rx_far_end (
   input wire logic i_clk,
   input wire logic i_clr,
   input wire logic i_clk_out,
   input wire logic i_data,
   input wire logic i_fp,
   input wire logic i_mux_fp,
   output logic [7:0] o_tx_data,
   output int o_clks,
   output int o_ones,
   output int o_fps,
   output int o_mux_fps
);
   logic fp_q = 1'b0;
   // All-zero payload and F-bits: each superframe holds an even count of ones
   assign o_tx_data = 8'h00;
   // Data is only taken with the backplane clock, as a real switch would
   always @(posedge i_clk) begin
      fp_q <= i_fp;
      o_clks <= i_clr ? 0 : o_clks + int'(i_clk_out);
      o_ones <= i_clr ? 0 : o_ones + int'(i_clk_out && i_data);
      o_fps <= i_clr ? 0 : o_fps + int'(i_fp && !fp_q);
      o_mux_fps <= i_clr ? 0 : o_mux_fps + int'(i_mux_fp);
   end
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the receive control block
`timescale 1ns/10ps
module tb;
   import t1rx_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, stb = 1'b0, fb = 1'b0;
   logic mf = 1'b0, lb = 1'b0, tick = 1'b0, clr = 1'b0, mfp, irq;
   logic [9:0] addr = 10'h000;
   logic [7:0] wd = 8'h00, red = 8'h00, loss = 8'h00, man = 8'h00, req = 8'h00;
   logic [7:0] rdat, bd, bclk, fp, srch, frz, alm, xfer, txd;
   logic [15:0] rate;
   int num_errors = 0, compares = 0, bc = 0, fc = 0, clks, ones, fps, mfps;
   logic [7:0] mt [8][4] = '{'{8'h80, 8'h40, 1, 0}, '{8'h84, 8'h40, 1, 0},
      '{8'h80, 8'h40, 1, 0}, '{8'h82, 8'h40, 0, 1}, '{8'h80, 8'h41, 0, 0},
      '{8'h80, 8'h00, 0, 0}, '{8'h00, 8'hC0, 0, 0}, '{8'h00, 8'h40, 0, 0}};
   int mx [8][2] = '{'{193, 96}, '{193, 192}, '{193, 96}, '{193, 192}, '{193, 192},
      '{0, 0}, '{0, 0}, '{193, 96}};
   logic [7:0] at [4][4] = '{'{8'h00, 1, 0, 0}, '{8'h00, 0, 1, 1}, '{8'h08, 1, 0, 1},
      '{8'h08, 0, 0, 0}};
   logic [7:0] xt [3][4] = '{'{8'h01, 1, 0, 1}, '{8'h00, 1, 0, 0}, '{8'h00, 0, 1, 1}};
   logic [7:0] fs [3] = '{8'h40, 8'h42, 8'h44};
   int fe [3] = '{12, 6, 1};

   t1rx_ctrl i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wr_stb(wr_s),
      .i_rd_stb(rd_s), .i_wdata(wd), .o_rdata(rdat), .i_line_bit_stb({8{stb}}),
      .i_line_bit({8{lb}}), .i_line_fbit({8{fb}}), .i_line_mf_start({8{mf}}),
      .i_ext_sig_bit(8'h00), .i_channel_select_bit(8'h00), .i_ts_condition(8'h00),
      .i_trunk_data_bit(8'hFF), .i_trunk_sig_bit(8'h00), .i_red_alarm(red),
      .i_frame_loss_indication(loss), .i_manual_remote_alarm(man),
      .i_one_second_tick(tick), .i_mcu_transfer_req(req), .i_tx_bit_stb({8{stb}}),
      .i_tx_fbit({8{fb}}), .i_tx_mf_start({8{mf}}), .i_tx_backplane_data(txd),
      .i_tx_backplane_signaling(txd), .o_rx_backplane_data(bd),
      .o_rx_backplane_signaling(), .o_rx_backplane_clock_out(bclk), .o_rx_frame_pulse(fp),
      .o_mux_rx_frame_pulse(mfp), .o_backplane_rate(rate), .o_frame_search_en(srch),
      .o_sig_buffer_freeze(frz), .o_loop_cmp_stb(), .o_send_remote_alarm(alm),
      .o_counter_transfer(xfer), .o_irq(irq));
   t1rx_far_end i_far (.i_clk(clk), .i_clr(clr), .i_clk_out(bclk[0]), .i_data(bd[0]),
      .i_fp(fp[0]), .i_mux_fp(mfp), .o_tx_data(txd), .o_clks(clks), .o_ones(ones),
      .o_fps(fps), .o_mux_fps(mfps));

   ////////////////////////////////////////
   // 50 MHz clock
   always #10 clk = ~clk;
   // Line stream: a bit every other cycle, 193-bit frames, 12-frame superframe
   always @(posedge clk) begin
      if (rstn && !stb) begin
         stb <= 1'b1;
         fb <= (bc == 0);
         mf <= (bc == 0) && (fc == 0);
         lb <= bc[0];
         bc <= (bc == 192) ? 0 : bc + 1;
         fc <= (bc != 192) ? fc : (fc == 11) ? 0 : fc + 1;
      end else begin
         stb <= 1'b0;
      end
   end
   ////////////////////////////////////////
   // Comparison and closing helpers
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %0t value %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic chkn(input int g, input int e);
      compares++;
      if (g != e) begin
         num_errors++;
         $display("BAD %0t count %0d expected %0d", $time, g, e);
      end
   endtask
   task automatic conclude;
      if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Register port cycles: strobe held one edge, data read after it lands
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk(16'(rdat), 16'(e));
   endtask
   // Settings only land at a frame boundary, so waits are whole frames
   task automatic frames(input int n);
      repeat (n * 386) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic window(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   ////////////////////////////////////////
   // Watchdog well beyond the expected run
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int g = 0; g < 8; g += 7) begin
         rd_chk(10'(g * 128), 8'h00);
         rd_chk(10'(g * 128 + 1), 8'hC0);
         rd_chk(10'(g * 128 + 2), 8'h00);
         rd_chk(10'(g * 128 + 3), 8'h00);
      end
      wr(10'h003, 8'hFF);
      rd_chk(10'h003, 8'h00);
      wr(10'h180, 8'hEF);
      wr(10'h182, 8'hFF);
      rd_chk(10'h180, 8'hEF);
      rd_chk(10'h182, 8'hCB);
      rd_chk(10'h000, 8'h00);
      wr(10'h182, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(10'h000, mt[i][0]);
         wr(10'h001, mt[i][1]);
         red <= {8{mt[i][2][0]}};
         loss <= {8{mt[i][3][0]}};
         frames(2);
         window(386);
         chkn(clks, mx[i][0]);
         chkn(ones, mx[i][1]);
      end
      for (int i = 0; i < 3; i++) begin
         wr(10'h001, fs[i]);
         frames(2);
         window(4632);
         chkn(fps, fe[i]);
      end
      for (int g = 0; g < 8; g++) wr(10'(g * 128 + 1), 8'hC8);
      frames(2);
      chk(rate, 16'h5555);
      window(386);
      chkn(mfps, 1);
      for (int c = 0; c < 4; c++) begin
         wr(10'h001, 8'hC0 | 8'(c << 3));
         frames(2);
         chk(rate, {14'h1555, 2'(c)});
      end
      for (int g = 0; g < 8; g++) wr(10'(g * 128 + 1), 8'hC0);
      for (int i = 0; i < 4; i++) begin
         wr(10'h000, at[i][0]);
         red <= {8{at[i][1][0]}};
         man <= {8{at[i][2][0]}};
         frames(1);
         chk(16'(alm[0]), 16'(at[i][3]));
      end
      for (int i = 0; i < 3; i++) begin
         wr(10'h000, xt[i][0]);
         frames(1);
         @(posedge clk);
         tick <= xt[i][1][0];
         req <= {8{xt[i][2][0]}};
         @(negedge clk);
         chk(16'(xfer[0]), 16'(xt[i][3]));
         @(posedge clk);
         tick <= 1'b0;
         req <= 8'h00;
      end
      wr(10'h000, 8'h40);
      frames(1);
      chk(16'({srch[0], frz[0]}), 16'h1);
      wr(10'h000, 8'h00);
      wr(10'h002, 8'hC0);
      frames(36);
      chk(16'(irq), 16'h1);
      // Switch type first so no stale-type check can set a flag after the clearing read
      wr(10'h002, 8'h40);
      frames(1);
      rd_chk(10'h002, 8'h70);
      chk(16'(irq), 16'h0);
      frames(36);
      rd_chk(10'h002, 8'h40);
      conclude();
   end
endmodule
